// ### src/kms_pkg.sv
// Shared constants of the key matrix scanner: register map, fields, reset values and timing
package kms_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SETUP    = 4'h0;  // Scan setup word
  localparam logic [3:0] ADDR_WAKE_EN  = 4'h1;  // keyscan_wake_enable
  localparam logic [3:0] ADDR_WAKE_REQ = 4'h2;  // keyscan_wake_request
  localparam logic [3:0] ADDR_STATUS   = 4'h3;  // keyscan_event_status and state
  localparam logic [3:0] ADDR_KEYDATA  = 4'h4;  // Returns caught at last scan end

  // ----------------------------------------------------------------
  // Field positions of the scan setup word
  // ----------------------------------------------------------------
  localparam int SETUP_COL_LSB   = 0;   // column_select_field, four bits
  localparam int SETUP_COL_W     = 4;
  localparam int SETUP_PAT_B0    = 4;   // scan_pattern_select low bit
  localparam int SETUP_PAT_B1    = 5;   // scan_pattern_select middle bit
  localparam int SETUP_CAUSE_BIT = 6;   // wake_cause_select
  localparam int SETUP_PAT_B2    = 7;   // scan_pattern_select high bit

  // Wake enable and request share one bit position
  localparam int WAKE_BIT = 5;

  // Status fields
  localparam int STATUS_EVENT_BIT   = 0;  // keyscan_event_status
  localparam int STATUS_PRESSED_BIT = 1;  // Key seen at last scan end
  localparam int STATUS_RUN_BIT     = 2;  // Scanner running
  localparam int STATUS_STOP_BIT    = 3;  // Stop mode seen

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RESET   = 8'h20;  // Pattern 010: scanning off
  localparam logic       WAKE_EN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Scan pattern codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PAT_ONE   = 3'h0;  // 000
  localparam logic [2:0] PAT_ALL   = 3'h1;  // 001
  localparam logic [2:0] PAT_OFF   = 3'h2;  // 010
  localparam logic [1:0] PAT_EIGHT = 2'h2;  // 10X, top two bits
  localparam logic [2:0] PAT_FOUR  = 3'h6;  // 110
  localparam logic [2:0] PAT_TWO   = 3'h7;  // 111

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ      = 100_000_000;
  localparam int     SCAN_MULT     = 2;      // Scan rate = frame * duty * 2
  localparam int     FRAME_HZ_DEF  = 64;
  localparam int     DUTY_DEF      = 4;
  localparam longint SCAN_PULSE_NS = 2000;   // Low pulse at end of each slot
  localparam int     PULSE_CYCLES  = int'((SCAN_PULSE_NS * CLOCK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  typedef enum logic [1:0] {
    KMS_OFF,
    KMS_SCAN,
    KMS_STOP
  } kms_state_e;

endpackage

// ### src/kms_column_mask.sv
// Registered decoder from scan pattern and column field to the active column mask
module kms_column_mask (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [2:0]  pattern,
  input  wire logic [3:0]  colField,
  output logic      [15:0] activeMask
);

  logic [15:0] activeMask_next;

  // Which columns take part in a scan cycle
  function automatic logic [15:0] decodeMask(input logic [2:0] pat, input logic [3:0] col);
    logic [15:0] m;
    m = 16'h0000;
    if (pat == kms_pkg::PAT_ONE)
      m = 16'h0001 << col;                              // [RQ6]
    else if (pat == kms_pkg::PAT_ALL)
      m = 16'hffff;                                     // [RQ7]
    else if (pat[2:1] == kms_pkg::PAT_EIGHT)
      m = col[3] ? 16'hff00 : 16'h00ff;                 // [RQ9]
    else if (pat == kms_pkg::PAT_FOUR)
      m = 16'h000f << {col[3:2], 2'h0};                 // [RQ10]
    else if (pat == kms_pkg::PAT_TWO)
      m = 16'h0003 << {col[3:1], 1'h0};                 // [RQ11]
    else
      m = 16'h0000;                                     // [RQ8]
    return m;
  endfunction

  // Next mask
  always_comb
  begin
    activeMask_next = decodeMask(pattern, colField);
  end

  // Mask register
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      activeMask <= 16'h0000;
    else
      activeMask <= activeMask_next;
  end

endmodule

// ### src/kms_key_matrix_scanner.sv
// Key matrix scanner sharing sixteen segment lines as scan columns
//
// How it works
// (RQ1) Scan rate is frame rate times duty times two
// (RQ2) Sixteen scan columns, four return inputs
// (RQ3) Build option enables self-running hardware scanning
// (RQ4) Cause 0: request on key press, then status
// (RQ5) Cause 1: request every scan end, then status
// (RQ6) Pattern 000: one column chosen by field
// (RQ7) Pattern 001: all sixteen columns, field ignored
// (RQ8) Pattern 010: scanning off, field ignored
// (RQ9) Pattern 10X: eight columns by bit three
// (RQ10) Pattern 110: four columns by bits three, two
// (RQ11) Pattern 111: column pair by bits three to one
// (RQ12) Return held low means key pressed
// (RQ13) Short low pulse on active columns per slot
// (RQ14) Stop mode: columns low, return pull-up on
// (RQ15) Software sets enable, clears request before halting
// (RQ16) Request sticky until cleared; none while disabled
//
// The placing of the registers and the plain strobed port were decided locally.
module kms_key_matrix_scanner #(
  parameter int FRAME_HZ    = kms_pkg::FRAME_HZ_DEF,
  parameter int DUTY_COUNT  = kms_pkg::DUTY_DEF,
  parameter bit KEYSCAN_OPT = 1'b1,
  parameter int SLOT_CYCLES = int'(kms_pkg::CLOCK_HZ / (FRAME_HZ * DUTY_COUNT * kms_pkg::SCAN_MULT))
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  input  wire logic [15:0] segmentDrive,
  input  wire logic        stopMode,
  input  wire logic [3:0]  keyReturnInputs,
  output logic      [15:0] keyScanColumns,
  output logic             returnPullUpEnable,
  output logic             keyscanWakeRequest
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DUTY_COUNT < 2 || DUTY_COUNT > 5)
  begin : g_duty_chk
    $error("Duty count must lie between 2 and 5");
  end
  if (SLOT_CYCLES < kms_pkg::PULSE_CYCLES + 2)
  begin : g_slot_chk
    $error("Scan slot too short for the column pulse");
  end

  // Slot counter size
  localparam int CNT_W = $clog2(SLOT_CYCLES + 1);
  localparam logic [CNT_W-1:0] SLOT_LAST   = CNT_W'(SLOT_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_START = CNT_W'(SLOT_CYCLES - kms_pkg::PULSE_CYCLES);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  setup_reg;
  logic [7:0]  setup_next;

  logic        wakeEn_reg;
  logic        wakeEn_next;

  logic        wakeReq_reg;
  logic        wakeReq_next;

  logic        eventStatus_reg;
  logic        eventStatus_next;

  logic        statusPend_reg;
  logic        statusPend_next;

  logic        pressed_reg;
  logic        pressed_next;

  logic [3:0]  keyData_reg;
  logic [3:0]  keyData_next;

  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  // ----------------------------------------------------------------
  // Scan engine state
  // ----------------------------------------------------------------
  kms_pkg::kms_state_e state_reg;
  kms_pkg::kms_state_e state_next;

  logic [CNT_W-1:0]    slotCnt_reg;
  logic [CNT_W-1:0]    slotCnt_next;

  logic [15:0]         columns_reg;
  logic [15:0]         columns_next;

  logic                pullUp_reg;
  logic                pullUp_next;

  // ----------------------------------------------------------------
  // Decoded setup fields
  // ----------------------------------------------------------------
  logic [2:0]  patternSel;
  logic [3:0]  colField;
  logic        causeSel;
  logic        scanAllowed;
  logic [15:0] activeMask;
  logic        inPulse;
  logic        scanEnd;
  logic        keySeen;
  logic        wakeSet;
  logic        wrHit;

  // Field split of the setup word
  always_comb
  begin
    patternSel  = {setup_reg[kms_pkg::SETUP_PAT_B2], setup_reg[kms_pkg::SETUP_PAT_B1],
                   setup_reg[kms_pkg::SETUP_PAT_B0]};
    colField    = setup_reg[kms_pkg::SETUP_COL_LSB +: kms_pkg::SETUP_COL_W];
    causeSel    = setup_reg[kms_pkg::SETUP_CAUSE_BIT];
    // Code 011 is not defined, so it is treated as scanning off
    scanAllowed = KEYSCAN_OPT && (patternSel != kms_pkg::PAT_OFF)            // [RQ3] [RQ8]
                  && (patternSel != 3'h3);
  end

  // Column mask decoder, registered so the pulse sees a settled mask
  kms_column_mask u_mask (
    .clock      (clock),
    .reset_n    (reset_n),
    .pattern    (patternSel),
    .colField   (colField),
    .activeMask (activeMask)
  );

  // ----------------------------------------------------------------
  // Scan engine
  // ----------------------------------------------------------------

  // Slot timing: pulse window closes each slot of frame/duty/2 period
  always_comb
  begin
    inPulse = (state_reg == kms_pkg::KMS_SCAN) && (slotCnt_reg >= PULSE_START);  // [RQ13]
    scanEnd = (state_reg == kms_pkg::KMS_SCAN) && (slotCnt_reg == SLOT_LAST);    // [RQ1]

    // A return still low at the last pulse cycle is a held key; a full pulse is not
    keySeen = scanEnd && (activeMask != 16'h0000) && (keyReturnInputs != 4'hf); // [RQ12]
  end

  // Next state, counter and pin values
  always_comb
  begin
    state_next   = state_reg;
    slotCnt_next = slotCnt_reg;
    columns_next = segmentDrive;
    pullUp_next  = 1'b0;
    case (state_reg)
      // Idle until allowed
      kms_pkg::KMS_OFF:
      begin
        slotCnt_next = '0;
        if (stopMode)
          state_next = kms_pkg::KMS_STOP;
        else if (scanAllowed)
          state_next = kms_pkg::KMS_SCAN;                                   // [RQ3]
      end
      // Count, dip in window
      kms_pkg::KMS_SCAN:
      begin
        if (stopMode)
        begin
          state_next   = kms_pkg::KMS_STOP;
          slotCnt_next = '0;
        end
        else if (!scanAllowed)
        begin
          state_next   = kms_pkg::KMS_OFF;
          slotCnt_next = '0;
        end
        else if (scanEnd)
          slotCnt_next = '0;                                                // [RQ1]
        else
          slotCnt_next = slotCnt_reg + 1'b1;

        // Only active columns dip; the display level is kept elsewhere
        if (inPulse)
          columns_next = segmentDrive & ~activeMask;                        // [RQ13] [RQ2]
      end
      // Held until stop lifts
      kms_pkg::KMS_STOP:
      begin
        slotCnt_next = '0;
        if (!stopMode)
          state_next = kms_pkg::KMS_OFF;
      end
      // Recover to idle
      default:
      begin
        state_next   = kms_pkg::KMS_OFF;
        slotCnt_next = '0;
      end
    endcase

    // Stop overrides the display drive at once
    if (stopMode || state_next == kms_pkg::KMS_STOP)
    begin
      columns_next = 16'h0000;                                              // [RQ14]
      pullUp_next  = 1'b1;                                                  // [RQ14]
    end
  end

  // Engine registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg   <= kms_pkg::KMS_OFF;
      slotCnt_reg <= '0;
      columns_reg <= 16'h0000;
      pullUp_reg  <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      slotCnt_reg <= slotCnt_next;
      columns_reg <= columns_next;
      pullUp_reg  <= pullUp_next;
    end
  end

  // ----------------------------------------------------------------
  // Wake request and status
  // ----------------------------------------------------------------

  // Raise cause: key press or every scan end; never while idle
  always_comb
  begin
    wakeSet = wakeEn_reg && (causeSel ? scanEnd : keySeen);                 // [RQ4] [RQ5] [RQ16]
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------

  // Register writes, sticky flags with set winning over clear
  always_comb
  begin
    wrHit            = regWrite;
    setup_next       = setup_reg;
    wakeEn_next      = wakeEn_reg;
    wakeReq_next     = wakeReq_reg;
    eventStatus_next = eventStatus_reg;
    statusPend_next  = wakeSet;
    pressed_next     = pressed_reg;
    keyData_next     = keyData_reg;
    // Software writes
    if (wrHit && regAddr == kms_pkg::ADDR_SETUP)
      setup_next = regWdata;                                                // [RQ6]
    else if (wrHit && regAddr == kms_pkg::ADDR_WAKE_EN)
      wakeEn_next = regWdata[kms_pkg::WAKE_BIT];                            // [RQ15]
    else if (wrHit && regAddr == kms_pkg::ADDR_WAKE_REQ && regWdata[kms_pkg::WAKE_BIT])
      wakeReq_next = 1'b0;                                                  // [RQ15] [RQ16]
    else if (wrHit && regAddr == kms_pkg::ADDR_STATUS && regWdata[kms_pkg::STATUS_EVENT_BIT])
      eventStatus_next = 1'b0;

    // Hardware set lands after the clear so it is never lost
    if (wakeSet)
      wakeReq_next = 1'b1;                                                  // [RQ16]

    // Status follows the request one cycle later
    if (statusPend_reg)
      eventStatus_next = 1'b1;                                              // [RQ4] [RQ5]

    // Latch returns at end
    if (scanEnd)
    begin
      pressed_next = keySeen;
      keyData_next = ~keyReturnInputs;                                      // [RQ12]
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    if (regRead)
    begin
      // Address decode
      if (regAddr == kms_pkg::ADDR_SETUP)
        rdata_next = setup_reg;
      else if (regAddr == kms_pkg::ADDR_WAKE_EN)
        rdata_next = 8'(wakeEn_reg) << kms_pkg::WAKE_BIT;
      else if (regAddr == kms_pkg::ADDR_WAKE_REQ)
        rdata_next = 8'(wakeReq_reg) << kms_pkg::WAKE_BIT;
      else if (regAddr == kms_pkg::ADDR_STATUS)
      begin
        rdata_next[kms_pkg::STATUS_EVENT_BIT]   = eventStatus_reg;
        rdata_next[kms_pkg::STATUS_PRESSED_BIT] = pressed_reg;
        rdata_next[kms_pkg::STATUS_RUN_BIT]     = (state_reg == kms_pkg::KMS_SCAN);
        rdata_next[kms_pkg::STATUS_STOP_BIT]    = (state_reg == kms_pkg::KMS_STOP);
      end
      else if (regAddr == kms_pkg::ADDR_KEYDATA)
        rdata_next = {4'h0, keyData_reg};
      else
        rdata_next = 8'h00;                                                 // Unmapped reads zero
    end
  end

  // Register file flops
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      setup_reg       <= kms_pkg::SETUP_RESET;
      wakeEn_reg      <= kms_pkg::WAKE_EN_RESET;
      wakeReq_reg     <= 1'b0;
      eventStatus_reg <= 1'b0;
      statusPend_reg  <= 1'b0;
      pressed_reg     <= 1'b0;
      keyData_reg     <= 4'h0;
      rdata_reg       <= 8'h00;
    end
    else
    begin
      setup_reg       <= setup_next;
      wakeEn_reg      <= wakeEn_next;
      wakeReq_reg     <= wakeReq_next;
      eventStatus_reg <= eventStatus_next;
      statusPend_reg  <= statusPend_next;
      pressed_reg     <= pressed_next;
      keyData_reg     <= keyData_next;
      rdata_reg       <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign regRdata           = rdata_reg;
  assign keyScanColumns     = columns_reg;
  assign returnPullUpEnable = pullUp_reg;
  assign keyscanWakeRequest = wakeReq_reg;

endmodule

// ### sim/kms_scanner_sva.sv
// Port-level checker for the key matrix scanner
module kms_scanner_sva (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic [15:0] segmentDrive,
  input wire logic        stopMode,
  input wire logic [3:0]  keyReturnInputs,
  input wire logic [15:0] keyScanColumns,
  input wire logic        returnPullUpEnable,
  input wire logic        keyscanWakeRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] setup_reg, setup_next;
  logic       en_reg, en_next;
  logic [2:0] offCnt_reg, offCnt_next, stopCnt_reg, stopCnt_next, enOffCnt_reg, enOffCnt_next;
  logic       clrWr;
  // ----------------------------------------------------------------
  // Mirrors of software setup; counters settle past the pipeline
  // ----------------------------------------------------------------
  assign clrWr = regWrite && regAddr == kms_pkg::ADDR_WAKE_REQ && regWdata[kms_pkg::WAKE_BIT];
  always_comb
  begin
    setup_next    = (regWrite && regAddr == kms_pkg::ADDR_SETUP) ? regWdata : setup_reg;
    en_next       = (regWrite && regAddr == kms_pkg::ADDR_WAKE_EN) ? regWdata[kms_pkg::WAKE_BIT] : en_reg;
    offCnt_next   = (!setup_reg[7] && setup_reg[5]) ? offCnt_reg + {2'b0, offCnt_reg != 3'h7} : 3'h0;
    stopCnt_next  = stopMode ? stopCnt_reg + {2'b0, stopCnt_reg != 3'h7} : 3'h0;
    enOffCnt_next = !en_reg ? enOffCnt_reg + {2'b0, enOffCnt_reg != 3'h7} : 3'h0;
  end
  // Registers of the mirrors
  always_ff @(posedge clock)
  begin
    setup_reg    <= reset_n ? setup_next : kms_pkg::SETUP_RESET;
    en_reg       <= reset_n ? en_next : kms_pkg::WAKE_EN_RESET;
    offCnt_reg   <= reset_n ? offCnt_next : 3'h0;
    stopCnt_reg  <= reset_n ? stopCnt_next : 3'h0;
    enOffCnt_reg <= reset_n ? enOffCnt_next : 3'h0;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  stop_cols_low_a : assert property (stopMode |=> keyScanColumns == 16'h0000)
    else $error("Columns not low in stop");
  stop_pullup_a : assert property (stopMode |=> returnPullUpEnable)
    else $error("Pull-up missing in stop");
  run_no_pullup_a : assert property (!stopMode |=> !returnPullUpEnable)
    else $error("Pull-up on outside stop");
  stop_no_wake_a : assert property (stopCnt_reg >= 3'h3 |-> !$rose(keyscanWakeRequest))
    else $error("Wake request raised in stop");
  off_no_wake_a : assert property (offCnt_reg >= 3'h3 |-> !$rose(keyscanWakeRequest))
    else $error("Wake request raised with scan off");
  en_off_no_wake_a : assert property (enOffCnt_reg >= 3'h3 |-> !$rose(keyscanWakeRequest))
    else $error("Wake request raised while disabled");
  wake_sticky_a : assert property (keyscanWakeRequest && !clrWr |=> keyscanWakeRequest)
    else $error("Wake request dropped without clear");
  wake_clear_a : assert property (!en_reg && clrWr |=> !keyscanWakeRequest)
    else $error("Wake request not cleared");
  seg_intact_a : assert property (1'b1 |=> (keyScanColumns & ~$past(segmentDrive)) == 16'h0000)
    else $error("Column high where segment low");
  off_follow_a : assert property (offCnt_reg >= 3'h3 && !stopMode |=> keyScanColumns == $past(segmentDrive))
    else $error("Columns differ from segments with scan off");
endmodule

bind kms_key_matrix_scanner kms_scanner_sva chk (
  .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .segmentDrive(segmentDrive), .stopMode(stopMode),
  .keyReturnInputs(keyReturnInputs), .keyScanColumns(keyScanColumns),
  .returnPullUpEnable(returnPullUpEnable), .keyscanWakeRequest(keyscanWakeRequest)
);

// ### sim/kms_switch_matrix.sv
// Passive four by sixteen key switch matrix on the scan columns
module kms_switch_matrix (
  input wire logic [15:0] keyScanColumns,
  input wire logic [63:0] keyClosed,
  output logic     [3:0]  keyReturnInputs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Returns rest high; a closed key copies a low column onto its row
  // ----------------------------------------------------------------
  always_comb
  begin
    keyReturnInputs = 4'hf;
    for (int c = 0; c < 16; c++)
      for (int r = 0; r < 4; r++)
        if (keyClosed[c * 4 + r] && !keyScanColumns[c])
          keyReturnInputs[r] = 1'b0;
  end
endmodule

// ### sim/tb_kms_key_matrix_scanner.sv
// Self-checking bench of the key matrix scanner
module tb_kms_key_matrix_scanner;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          SIM_SLOT = 300;  // Short slot keeps the run brief
  localparam logic [15:0] ALL_HIGH = 16'hffff;
  logic        clock, reset_n, regWrite, regRead, stopMode, returnPullUpEnable, keyscanWakeRequest, rdPend;
  logic [3:0]  regAddr, keyReturnInputs, col;
  logic [1:0]  row;
  logic [7:0]  regWdata, regRdata;
  logic [15:0] segmentDrive, keyScanColumns, low1, low2;
  logic [63:0] keyClosed;
  logic [31:0] rnd;
  logic [7:0]  expQ[$];
  logic [2:0]  patCodes[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  int          nErrors, totalChecks, cyc, d1, d2, s1, s2;

  kms_key_matrix_scanner #(.SLOT_CYCLES(SIM_SLOT)) uut (
    .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .segmentDrive(segmentDrive), .stopMode(stopMode),
    .keyReturnInputs(keyReturnInputs), .keyScanColumns(keyScanColumns),
    .returnPullUpEnable(returnPullUpEnable), .keyscanWakeRequest(keyscanWakeRequest)
  );
  kms_switch_matrix matrix (.keyScanColumns(keyScanColumns), .keyClosed(keyClosed), .keyReturnInputs(keyReturnInputs));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] expMask(input logic [2:0] p, input logic [3:0] f);
    case (p)
      3'h0: return 16'h0001 << f;
      3'h1: return 16'hffff;
      3'h6: return 16'h000f << {f[3:2], 2'b00};
      3'h7: return 16'h0003 << {f[3:1], 1'b0};
      default: return f[3] ? 16'hff00 : 16'h00ff;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes; the next call always lets an edge pass first
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  task automatic waitReq(input int limit);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (keyscanWakeRequest !== 1'b1 && n < limit);
  endtask
  // Measures one scan pulse with all segments held high
  task automatic pulse(output logic [15:0] lowSet, output int dur, output int start);
    int n;
    n = 0;
    while (keyScanColumns === ALL_HIGH && n < 2 * SIM_SLOT)
    begin
      @(negedge clock);
      n++;
    end
    start = cyc;
    lowSet = ~keyScanColumns;
    dur = 0;
    while (keyScanColumns !== ALL_HIGH && dur < 2 * SIM_SLOT)
    begin
      @(negedge clock);
      dur++;
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, read-data monitor, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Read data counts only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rdPend && expQ.size() > 0)
      chk({8'h00, regRdata}, {8'h00, expQ.pop_front()});
    rdPend <= regRead;
    cyc <= cyc + 1;
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    nErrors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset_n, regWrite, regRead, stopMode, regAddr, regWdata} = '0;
    {segmentDrive, keyClosed, rnd} = {ALL_HIGH, 64'h0, 32'hc1af13ba};
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rd(kms_pkg::ADDR_SETUP, kms_pkg::SETUP_RESET);
    rd(kms_pkg::ADDR_WAKE_EN, 8'h00);
    rd(kms_pkg::ADDR_STATUS, 8'h00);
    rd(4'hf, 8'h00);
    // Every scanning pattern code, 010 and 011 aside; first pulse after a change is skipped
    foreach (patCodes[i])
    begin
      rnd = lfsrNext(rnd);
      wr(kms_pkg::ADDR_SETUP, {patCodes[i][2], 1'b0, patCodes[i][1:0], rnd[3:0]});
      pulse(low2, d2, s2);
      pulse(low1, d1, s1);
      pulse(low2, d2, s2);
      chk(low1, expMask(patCodes[i], rnd[3:0]));
      chk(16'(d1), 16'(kms_pkg::PULSE_CYCLES));
      chk(16'(s2 - s1), 16'(SIM_SLOT));
    end
    rd(kms_pkg::ADDR_STATUS, 8'h04);
    // Key on a neighbour column is unseen, then on the chosen column
    {col, row} = rnd[9:4];
    wr(kms_pkg::ADDR_SETUP, {4'h0, col});
    wr(kms_pkg::ADDR_WAKE_EN, 8'h20);
    wr(kms_pkg::ADDR_WAKE_REQ, 8'h20);
    keyClosed <= 64'h1 << {col + 4'h1, row};
    repeat (2 * SIM_SLOT) @(negedge clock);
    chk({15'h0, keyscanWakeRequest}, 16'h0000);
    @(posedge clock);
    keyClosed <= 64'h1 << {col, row};
    waitReq(2 * SIM_SLOT);
    chk({15'h0, keyscanWakeRequest}, 16'h0001);
    rd(kms_pkg::ADDR_STATUS, 8'h07);
    rd(kms_pkg::ADDR_KEYDATA, {4'h0, 4'h1 << row});
    keyClosed <= 64'h0;
    repeat (SIM_SLOT + 5) @(negedge clock);
    chk({15'h0, keyscanWakeRequest}, 16'h0001);
    wr(kms_pkg::ADDR_WAKE_REQ, 8'h20);
    wr(kms_pkg::ADDR_STATUS, 8'h01);
    rd(kms_pkg::ADDR_STATUS, 8'h04);
    rd(kms_pkg::ADDR_WAKE_REQ, 8'h00);
    // Request on every scan end, with no key pressed
    wr(kms_pkg::ADDR_SETUP, 8'h50);
    waitReq(2 * SIM_SLOT);
    chk({15'h0, keyscanWakeRequest}, 16'h0001);
    rd(kms_pkg::ADDR_STATUS, 8'h05);
    wr(kms_pkg::ADDR_WAKE_REQ, 8'h20);
    waitReq(2 * SIM_SLOT);
    chk({15'h0, keyscanWakeRequest}, 16'h0001);
    wr(kms_pkg::ADDR_WAKE_EN, 8'h00);
    wr(kms_pkg::ADDR_WAKE_REQ, 8'h20);
    wr(kms_pkg::ADDR_STATUS, 8'h01);
    repeat (2 * SIM_SLOT) @(negedge clock);
    chk({15'h0, keyscanWakeRequest}, 16'h0000);
    // Scanning off while segments wander at random
    wr(kms_pkg::ADDR_SETUP, {4'h2, rnd[3:0]});
    wr(kms_pkg::ADDR_WAKE_EN, 8'h20);
    repeat (2 * SIM_SLOT)
    begin
      @(posedge clock);
      rnd = lfsrNext(rnd);
      segmentDrive <= rnd[15:0];
    end
    segmentDrive <= ALL_HIGH;
    chk({15'h0, keyscanWakeRequest}, 16'h0000);
    wr(kms_pkg::ADDR_SETUP, 8'h30);
    repeat (SIM_SLOT) @(negedge clock);
    rd(kms_pkg::ADDR_STATUS, 8'h00);
    // Stop mode, then resume
    wr(kms_pkg::ADDR_SETUP, 8'h50);
    stopMode <= 1'b1;
    repeat (2 * SIM_SLOT) @(negedge clock);
    chk({15'h0, keyscanWakeRequest}, 16'h0000);
    chk({15'h0, returnPullUpEnable}, 16'h0001);
    chk(keyScanColumns, 16'h0000);
    rd(kms_pkg::ADDR_STATUS, 8'h08);
    stopMode <= 1'b0;
    waitReq(2 * SIM_SLOT + 4);
    chk({15'h0, keyscanWakeRequest}, 16'h0001);
    // Second reset in mid-run
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(kms_pkg::ADDR_SETUP, kms_pkg::SETUP_RESET);
    chk({15'h0, keyscanWakeRequest}, 16'h0000);
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule
